// [inc/dbs_pkg.sv]
// Shared constants of the two-word-burst DDR SRAM bus model
package dbs_pkg;

    // ****************************************************************
    // Clock rate and timing figures
    // ****************************************************************
    localparam int CLK_MHZ        = 25;        // System sampling clock rate
    localparam int KC_RESET_NS    = 30;        // Input clock static time to PLL reset
    localparam int KC_LOCK_US     = 20;        // PLL lock time after clock resumes
    // Least times round up to whole cycles
    localparam int KC_RESET_CYC   = (KC_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int KC_LOCK_CYC    = (KC_LOCK_US * 1000 * CLK_MHZ + 999) / 1000;
    localparam int TIE_CYC        = 16;        // Cycles both output clocks high = tied

    // ****************************************************************
    // Read pipeline, counted in output clock half cycles
    // ****************************************************************
    localparam int PIPE_DEPTH     = 4;
    localparam int SLOT_PLL       = 2;         // First word 1.5 cycles after command
    localparam int SLOT_BYPASS    = 1;         // First word 1.0 cycle after command

    // ****************************************************************
    // Bit positions in the sampled pin vector
    // ****************************************************************
    localparam int PIN_K          = 0;
    localparam int PIN_K_N        = 1;
    localparam int PIN_C          = 2;
    localparam int PIN_C_N        = 3;
    localparam int PIN_BYPASS_N   = 4;
    localparam int PIN_STROBE_N   = 5;
    localparam int PIN_RW         = 6;
    localparam int PIN_ADDR       = 7;

    // ****************************************************************
    // Default sizes
    // ****************************************************************
    localparam int ADDR_W_DEF     = 4;
    localparam int DATA_W_DEF     = 18;
    localparam int BYTE_W_DEF     = 9;
    localparam int BUF_DEPTH_DEF  = 2;

endpackage

// [logic/dbs_pair_buf.sv]
// Small valid/ready buffer of flip-flops for captured write words
`timescale 1ns/1ps
module dbs_pair_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = dbs_pkg::BUF_DEPTH_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("dbs_pair_buf: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    // Full and empty flags from the fill level
    assign in_ready  = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = slot_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (PW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (PW+1)'(1);
            end
        end
    end

endmodule

// [logic/dbs_sram_dev.sv]
// Device-side bus behaviour of a two-word-burst DDR SRAM
// ****************************************************************
// Summary of operation
// - Bypass input low runs without PLL, read latency one clock cycle.
// - Input clock static for 30 ns resets the PLL; relock follows.
// - After read then no-operations, outputs float 2.5 cycles after last read with PLL, 2.0 cycles in bypass.
// - Read is strobe low with select high on K rise; strobe high is no-op.
// - Burst returns supplied address word, then next internal burst address word.
// - Both output clocks tied high make read outputs time from input clocks.
// - Command sampled on K rise only; write data on K and K# rises.
// - Echo clocks follow the output clocks, or the input clocks when output clocks are tied, one system cycle behind read data.
// ****************************************************************
`timescale 1ns/1ps
module dbs_sram_dev #(
    parameter int ADDR_W     = dbs_pkg::ADDR_W_DEF,
    parameter int DATA_W     = dbs_pkg::DATA_W_DEF,
    parameter int BYTE_W     = dbs_pkg::BYTE_W_DEF,
    parameter int STATIC_CYC = dbs_pkg::KC_RESET_CYC,
    parameter int LOCK_CYC   = dbs_pkg::KC_LOCK_CYC,
    parameter int TIE_CYC    = dbs_pkg::TIE_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       k,
    input  wire logic                       k_n,
    input  wire logic                       c,
    input  wire logic                       c_n,
    input  wire logic                       pll_bypass_n,
    input  wire logic                       cmd_strobe_n,
    input  wire logic                       rw_sel,
    input  wire logic [ADDR_W-1:0]          addr,
    input  wire logic [DATA_W/BYTE_W-1:0]   byte_write_select_n,
    input  wire logic [DATA_W-1:0]          dq_in,
    output logic      [DATA_W-1:0]          dq_out,
    output logic                            dq_oe,
    output logic                            echo_clk_true,
    output logic                            echo_clk_comp,
    output logic                            pll_locked,
    output logic                            read_latency,
    output logic                            wr_ready
);
    localparam int NBW  = DATA_W / BYTE_W;
    localparam int PINW = dbs_pkg::PIN_ADDR + ADDR_W + NBW + DATA_W;
    localparam int PBW  = dbs_pkg::PIN_ADDR + ADDR_W;
    localparam int PDQ  = PBW + NBW;
    localparam int EW   = ADDR_W + NBW + DATA_W;
    localparam int PD   = dbs_pkg::PIPE_DEPTH;

    generate
        if (ADDR_W < 1 || BYTE_W < 1 || DATA_W % BYTE_W != 0) begin : g_chk
            $error("dbs_sram_dev: DATA_W must be a multiple of BYTE_W");
        end
        if (STATIC_CYC < 1 || STATIC_CYC > 65535 || LOCK_CYC < 1 || LOCK_CYC > 65535
            || TIE_CYC < 1 || TIE_CYC > 255) begin : g_chk_t
            $error("dbs_sram_dev: timing counts out of range");
        end
    endgenerate

    // Partner address of a two-word burst
    function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
        burst_next = a ^ ADDR_W'(1);
    endfunction

    // ****************************************************************
    // Pin sampling: three flops, a change counts when stages 2 and 3 agree
    // ****************************************************************
    logic [PINW-1:0] pins;
    logic [PINW-1:0] s1_q;
    logic [PINW-1:0] s2_q;
    logic [PINW-1:0] s3_q;
    logic [PINW-1:0] lvl_q;
    logic [PINW-1:0] rise;
    logic [PINW-1:0] fall;

    assign pins = {dq_in, byte_write_select_n, addr, rw_sel, cmd_strobe_n,
                   pll_bypass_n, c_n, c, k_n, k};

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level follows only agreed values
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
        end
    end

    assign rise = s2_q & s3_q & ~lvl_q;
    assign fall = ~s2_q & ~s3_q & lvl_q;

    // ****************************************************************
    // Mode detection: bypass, tied output clocks, PLL lock
    // ****************************************************************
    logic        bypass;
    logic        c_tied_q;
    logic [7:0]  tie_cnt_q;
    logic [15:0] static_cnt_q;
    logic [15:0] lock_cnt_q;
    logic        k_change;

    assign bypass       = ~lvl_q[dbs_pkg::PIN_BYPASS_N];
    assign read_latency = bypass;
    assign k_change     = rise[dbs_pkg::PIN_K] | fall[dbs_pkg::PIN_K];

    // Output clocks held high together means tied off
    always_ff @(posedge clk) begin
        if (rst) begin
            tie_cnt_q <= '0;
            c_tied_q  <= 1'b0;
        end else if (lvl_q[dbs_pkg::PIN_C] && lvl_q[dbs_pkg::PIN_C_N]) begin
            if (tie_cnt_q != 8'(TIE_CYC)) begin
                tie_cnt_q <= tie_cnt_q + 8'h01;
            end
            c_tied_q <= (tie_cnt_q == 8'(TIE_CYC));
        end else begin
            tie_cnt_q <= '0;
            c_tied_q  <= 1'b0;
        end
    end

    // Static input clock resets the PLL, relock count restarts
    always_ff @(posedge clk) begin
        if (rst) begin
            static_cnt_q <= '0;
            lock_cnt_q   <= '0;
        end else begin
            if (k_change) begin
                static_cnt_q <= '0;
            end else if (static_cnt_q != 16'(STATIC_CYC)) begin
                static_cnt_q <= static_cnt_q + 16'h0001;
            end
            if (bypass || static_cnt_q == 16'(STATIC_CYC)) begin
                lock_cnt_q <= '0;
            end else if (lock_cnt_q != 16'(LOCK_CYC)) begin
                lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
        end
    end

    assign pll_locked = (lock_cnt_q == 16'(LOCK_CYC));

    // ****************************************************************
    // Command decode on the true input clock rise
    // ****************************************************************
    logic              k_rise;
    logic              kn_rise;
    logic              rd_cmd;
    logic              wr_cmd;
    logic [ADDR_W-1:0] cmd_addr;

    assign k_rise   = rise[dbs_pkg::PIN_K];
    assign kn_rise  = rise[dbs_pkg::PIN_K_N];
    assign cmd_addr = s3_q[PBW-1:dbs_pkg::PIN_ADDR];
    assign rd_cmd   = k_rise & ~s3_q[dbs_pkg::PIN_STROBE_N] & s3_q[dbs_pkg::PIN_RW];
    assign wr_cmd   = k_rise & ~s3_q[dbs_pkg::PIN_STROBE_N] & ~s3_q[dbs_pkg::PIN_RW];

    // ****************************************************************
    // Write capture: two words on the following K# and K rises
    // ****************************************************************
    typedef enum logic [1:0] {WR_IDLE, WR_WORD0, WR_WORD1} dbs_wr_type;
    dbs_wr_type        wr_st_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              push;
    logic [EW-1:0]     push_data;
    logic              buf_ready;
    logic              buf_valid;
    logic [EW-1:0]     buf_data;
    logic              drain;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_st_q   <= WR_IDLE;
            wr_addr_q <= '0;
        end else begin
            case (wr_st_q)
                WR_IDLE: begin
                    if (wr_cmd) begin
                        wr_st_q   <= WR_WORD0;
                        wr_addr_q <= cmd_addr;
                    end
                end
                WR_WORD0: begin
                    if (kn_rise) begin
                        wr_st_q <= WR_WORD1;
                    end
                end
                WR_WORD1: begin
                    if (k_rise) begin
                        wr_st_q   <= wr_cmd ? WR_WORD0 : WR_IDLE;
                        wr_addr_q <= wr_cmd ? cmd_addr : wr_addr_q;
                    end
                end
                default: begin
                    wr_st_q <= WR_IDLE;
                end
            endcase
        end
    end

    // Each captured word carries its address and byte selects
    assign push = (wr_st_q == WR_WORD0 && kn_rise) || (wr_st_q == WR_WORD1 && k_rise);
    assign push_data = {(wr_st_q == WR_WORD1) ? burst_next(wr_addr_q) : wr_addr_q,
                        s3_q[PDQ-1:PBW], s3_q[PINW-1:PDQ]};
    assign wr_ready  = buf_ready;
    // Array is busy on a read command edge; writes wait in the buffer
    assign drain     = ~rd_cmd;

    dbs_pair_buf #(
        .WIDTH (EW),
        .DEPTH (dbs_pkg::BUF_DEPTH_DEF)
    ) dbs_pair_buf_i (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (push_data),
        .out_valid (buf_valid),
        .out_ready (drain),
        .out_data  (buf_data)
    );

    // ****************************************************************
    // Storage array with byte-lane writes
    // ****************************************************************
    logic [DATA_W-1:0] mem_q [2**ADDR_W];
    logic [ADDR_W-1:0] buf_addr;
    logic [NBW-1:0]    buf_bws_n;

    assign buf_addr  = buf_data[EW-1:NBW+DATA_W];
    assign buf_bws_n = buf_data[NBW+DATA_W-1:DATA_W];

    // One process owns the array; each enabled lane lands as the word drains
    always_ff @(posedge clk) begin
        if (buf_valid && drain) begin
            for (int l = 0; l < NBW; l++) begin
                if (!buf_bws_n[l]) begin
                    mem_q[buf_addr][l*BYTE_W +: BYTE_W] <= buf_data[l*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // ****************************************************************
    // Read pipeline stepped by output clock rises
    // ****************************************************************
    logic              ref_t;
    logic              ref_c;
    logic              ref_edge;
    logic              pend_q;
    logic [ADDR_W-1:0] pend_addr_q;
    logic              ins;
    logic [ADDR_W-1:0] ins_addr;
    logic              pv_q [PD];
    logic [DATA_W-1:0] pd_q [PD];
    int                first;

    // Tied output clocks hand timing to the input clocks
    assign ref_t    = c_tied_q ? rise[dbs_pkg::PIN_K]   : rise[dbs_pkg::PIN_C];
    assign ref_c    = c_tied_q ? rise[dbs_pkg::PIN_K_N] : rise[dbs_pkg::PIN_C_N];
    assign ref_edge = ref_t | ref_c;
    assign ins      = ref_edge & (rd_cmd | pend_q);
    assign ins_addr = rd_cmd ? cmd_addr : pend_addr_q;
    assign first    = bypass ? dbs_pkg::SLOT_BYPASS : dbs_pkg::SLOT_PLL;

    // A read waits for the output clock edge that matches its K edge
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q      <= 1'b0;
            pend_addr_q <= '0;
        end else if (rd_cmd && !ref_edge) begin
            pend_q      <= 1'b1;
            pend_addr_q <= cmd_addr;
        end else if (ref_edge) begin
            pend_q      <= 1'b0;
        end
    end

    // Shift one slot per output edge, then place both burst words
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < PD; i++) begin
                pv_q[i] <= 1'b0;
                pd_q[i] <= '0;
            end
        end else if (ref_edge) begin
            for (int i = 0; i < PD; i++) begin
                pv_q[i] <= (i + 1 < PD) ? pv_q[(i + 1) % PD] : 1'b0;
                pd_q[i] <= (i + 1 < PD) ? pd_q[(i + 1) % PD] : '0;
                if (ins && i == first) begin
                    pv_q[i] <= 1'b1;
                    pd_q[i] <= mem_q[ins_addr];
                end
                if (ins && i == first + 1) begin
                    pv_q[i] <= 1'b1;
                    pd_q[i] <= mem_q[burst_next(ins_addr)];
                end
            end
        end
    end

    // ****************************************************************
    // Output drivers updated on each output edge, echo clocks on every system cycle
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else if (ref_edge) begin
            dq_out <= pd_q[0];
            dq_oe  <= pv_q[0];
        end
    end

    // Echo clocks follow the reference clocks one system cycle after the data edge
    always_ff @(posedge clk) begin
        if (rst) begin
            echo_clk_true <= 1'b0;
            echo_clk_comp <= 1'b0;
        end else begin
            echo_clk_true <= c_tied_q ? lvl_q[dbs_pkg::PIN_K]   : lvl_q[dbs_pkg::PIN_C];
            echo_clk_comp <= c_tied_q ? lvl_q[dbs_pkg::PIN_K_N] : lvl_q[dbs_pkg::PIN_C_N];
        end
    end

endmodule

// [verif/dbs_ctrl_model.sv]
// Controller-side clock model driving the input and output clock pins
`timescale 1ns/1ps
module dbs_ctrl_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       tie_c,
    output logic            k,
    output logic            k_n,
    output logic            c,
    output logic            c_n,
    output logic [2:0]      ph
);
    // ****************************************************************
    // Input clock of eight system cycles, held static when stopped
    // ****************************************************************
    // Phase counter; a stop parks it with k low for the static test
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            ph <= 3'h4;
        end else begin
            ph <= ph + 3'h1;
        end
    end

    // Equal high and low halves, complement rises half a cycle later
    assign k   = (ph < 3'h4);
    assign k_n = !k;
    // Output clocks follow the input pair unless both are tied high
    assign c   = tie_c | k;
    assign c_n = tie_c | k_n;
endmodule

// [verif/dbs_sram_dev_props.sv]
// Concurrent checks on the ports of the DDR burst SRAM device
`timescale 1ns/1ps
module dbs_sram_props #(
    parameter int DATA_W     = 18,
    parameter int STATIC_CYC = 16,
    parameter int LOCK_CYC   = 20
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              k,
    input wire logic              c,
    input wire logic              c_n,
    input wire logic              pll_bypass_n,
    input wire logic              cmd_strobe_n,
    input wire logic              rw_sel,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              echo_clk_true,
    input wire logic              echo_clk_comp,
    input wire logic              pll_locked,
    input wire logic              read_latency
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    logic        k_q;
    logic [7:0]  stat_q;
    logic [15:0] live_q;
    logic [16:0] hist_q;
    logic        rd_evt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Read command seen at a rising edge of the input clock
    assign rd_evt = k && !k_q && !cmd_strobe_n && rw_sel;

    // Previous clock level and history of read commands
    always_ff @(posedge clk) begin
        if (rst) begin
            k_q    <= 1'b0;
            hist_q <= 17'h0_0000;
        end else begin
            k_q    <= k;
            hist_q <= {hist_q[15:0], rd_evt};
        end
    end

    // Cycles the input clock stood still, and cycles it has run since
    always_ff @(posedge clk) begin
        if (rst || k != k_q) begin
            stat_q <= 8'h00;
        end else if (stat_q != 8'hff) begin
            stat_q <= stat_q + 8'h01;
        end
        if (rst || stat_q >= STATIC_CYC) begin
            live_q <= 16'h0000;
        end else if (live_q != 16'hffff) begin
            live_q <= live_q + 16'h0001;
        end
    end

    AST_BYP_LAT: assert property ($stable(pll_bypass_n) [*6] |-> read_latency == !pll_bypass_n)
        else $error("latency flag disagrees with bypass pin");
    AST_BYP_NOLOCK: assert property (!pll_bypass_n [*6] |-> !pll_locked)
        else $error("lock flag high in bypass");
    AST_BYP_START: assert property (rd_evt && !pll_bypass_n |-> ##[11:13] $rose(dq_oe))
        else $error("bypass read data late or missing");
    AST_STATIC: assert property (stat_q >= STATIC_CYC + 6 |-> !pll_locked)
        else $error("lock kept over a stopped clock");
    AST_LOCK: assert property ($rose(pll_locked) |-> live_q >= LOCK_CYC)
        else $error("lock reported too early");
    AST_OE_FLOAT: assert property ($rose(dq_oe) |-> dq_oe [*8] ##1 !dq_oe)
        else $error("data bus not released after burst");
    AST_NOP_QUIET: assert property ($rose(dq_oe) |-> |hist_q[16:10])
        else $error("data driven without a read command");
    AST_OE_START: assert property (rd_evt && pll_bypass_n |-> ##[15:17] $rose(dq_oe))
        else $error("read data late or missing");
    AST_OE_HOLD: assert property ($rose(dq_oe) |=> $stable(dq_out) [*3])
        else $error("first word changed within its half cycle");
    AST_ECHO: assert property (($stable(c) && c != c_n) [*8] |-> echo_clk_true == c && echo_clk_comp == c_n)
        else $error("echo clocks do not follow output clocks");
endmodule

bind dbs_sram_dev dbs_sram_props #(
    .DATA_W(DATA_W), .STATIC_CYC(STATIC_CYC), .LOCK_CYC(LOCK_CYC)
) dbs_sram_props_i (
    .clk(clk), .rst(rst), .k(k), .c(c), .c_n(c_n), .pll_bypass_n(pll_bypass_n),
    .cmd_strobe_n(cmd_strobe_n), .rw_sel(rw_sel), .dq_out(dq_out), .dq_oe(dq_oe),
    .echo_clk_true(echo_clk_true), .echo_clk_comp(echo_clk_comp),
    .pll_locked(pll_locked), .read_latency(read_latency)
);

// [verif/dbs_sram_dev_tb.sv]
// Self-checking bench for the DDR burst SRAM device side
`timescale 1ns/1ps
module dbs_sram_dev_tb;
    // ****************************************************************
    // Signals, design and controller model
    // ****************************************************************
    localparam int STAT = 16;
    localparam int LOCK = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        run = 1'b0;
    logic        tie_c = 1'b0;
    logic        byp_n = 1'b1;
    logic        strobe_n = 1'b1;
    logic        rw = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [1:0]  bws_n = 2'h3;
    logic [17:0] dq_in = 18'h0_0000;
    logic        k, k_n, c, c_n, dq_oe, e_t, e_c, locked, rl, wr_rdy;
    logic [2:0]  ph;
    logic [17:0] dq_out;
    logic [17:0] mem [16];
    logic [3:0]  ra [4] = '{4'h5, 4'h2, 4'h0, 4'h3};
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          lat_p, lat_b, lat_t;

    // System clock of 40 ns
    always #20 clk = ~clk;

    dbs_sram_dev #(.STATIC_CYC(STAT), .LOCK_CYC(LOCK)) dbs_sram_dev_i (
        .clk(clk), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .pll_bypass_n(byp_n),
        .cmd_strobe_n(strobe_n), .rw_sel(rw), .addr(addr), .byte_write_select_n(bws_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_clk_true(e_t),
        .echo_clk_comp(e_c), .pll_locked(locked), .read_latency(rl), .wr_ready(wr_rdy));
    dbs_ctrl_model dbs_ctrl_model_i (.clk(clk), .rst(rst), .run(run), .tie_c(tie_c),
        .k(k), .k_n(k_n), .c(c), .c_n(c_n), .ph(ph));

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({17'h0_0000, got}, {17'h0_0000, exp});
    endtask

    task automatic wait_ph(input logic [2:0] p);
        @(posedge clk iff ph == p);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_lock();
        for (int n = 0; n < LOCK * 4 && locked !== 1'b1; n++) settle(1);
    endtask

    // Write: command on k rise, word0 at the k_n rise, word1 at next k rise
    task automatic wr(input logic [3:0] a, input logic [17:0] d0, d1, input logic [1:0] bw);
        wait_ph(3'h5);
        strobe_n <= 1'b0;
        rw <= 1'b0;
        addr <= a;
        wait_ph(3'h1);
        strobe_n <= 1'b1;
        dq_in <= d0;
        bws_n <= bw;
        wait_ph(3'h5);
        dq_in <= d1;
        wait_ph(3'h1);
        dq_in <= ~d1;
        bws_n <= 2'h3;
        for (int i = 0; i < 2; i++) begin
            if (!bw[i]) begin
                mem[a][9*i +: 9] = d0[9*i +: 9];
                mem[a ^ 4'h1][9*i +: 9] = d1[9*i +: 9];
            end
        end
    endtask

    // Read: measure cycles from the k rise to the bus turning on
    task automatic rd(input logic [3:0] a, output int lat);
        int n;
        n = 0;
        wait_ph(3'h5);
        strobe_n <= 1'b0;
        rw <= 1'b1;
        addr <= a;
        wait_ph(3'h7);
        while (n < 40 && dq_oe !== 1'b1) begin
            @(posedge clk);
            if (n == 1) strobe_n <= 1'b1;
            #1;
            n++;
        end
        lat = n;
        cmp_word(dq_out, mem[a]);
        settle(4);
        cmp_word(dq_out, mem[a ^ 4'h1]);
        settle(4);
        cmp_flag(dq_oe, 1'b0);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        wait_lock();
        cmp_flag(locked, 1'b1);
        $display("test lock done");
        for (int i = 0; i < 8; i += 2) wr(4'(i), 18'h2_a000 + 18'(i), 18'h1_5000 + 18'(i), 2'h0);
        wr(4'h5, 18'h3_ffff, 18'h0_0000, 2'h1);
        wr(4'h2, 18'h1_2345, 18'h2_3456, 2'h2);
        for (int i = 0; i < 4; i++) rd(ra[i], lat_p);
        cmp_word(18'(lat_p), 18'h0_0010);
        cmp_flag(wr_rdy, 1'b1);
        $display("test write read done");
        @(posedge clk);
        byp_n <= 1'b0;
        settle(8);
        cmp_flag(rl, 1'b1);
        cmp_flag(locked, 1'b0);
        rd(4'h5, lat_b);
        cmp_word(18'(lat_p - lat_b), 18'h0_0004);
        @(posedge clk);
        byp_n <= 1'b1;
        settle(8);
        cmp_flag(rl, 1'b0);
        $display("test bypass done");
        wait_lock();
        @(posedge clk);
        run <= 1'b0;
        settle(STAT + 8);
        cmp_flag(locked, 1'b0);
        cmp_flag(e_t, 1'b0);
        cmp_flag(e_c, 1'b1);
        @(posedge clk);
        run <= 1'b1;
        settle(LOCK / 2);
        cmp_flag(locked, 1'b0);
        wait_lock();
        cmp_flag(locked, 1'b1);
        $display("test clock stop done");
        @(posedge clk);
        tie_c <= 1'b1;
        settle(dbs_pkg::TIE_CYC + 8);
        rd(4'h2, lat_t);
        cmp_word(18'(lat_t), 18'(lat_p));
        wr(4'h8, 18'h0_0abc, 18'h3_0cba, 2'h0);
        rd(4'h8, lat_t);
        $display("test tied clocks done");
        stop_test();
    end
endmodule
